// *** design/eac_pkg.sv ***
// eac_pkg: constants and carrier types for the eeprom access control block
// assumes the cpu i/o space uses 6-bit register offsets and 8-bit data
package eac_pkg;
  // i/o space offsets
  localparam logic [5:0] EAC_DATA_OFS = 6'h1d; // data register
  localparam logic [5:0] EAC_ADDR_OFS = 6'h1e; // address register
  localparam logic [5:0] EAC_CTRL_OFS = 6'h1c; // control register
  // control field positions
  localparam int EAC_RD_BIT = 0; // read strobe
  localparam int EAC_WR_BIT = 1; // write strobe
  localparam int EAC_ARM_BIT = 2; // write arm
  // reset values
  localparam logic [7:0] EAC_RST_VAL = 8'h00;
  localparam logic [7:0] EAC_ERASED = 8'hff; // erased cell content
  // timing
  localparam int EAC_CLK_HZ = 10_000_000;
  localparam int EAC_ARM_CYC = 4; // arm lifetime in cycles
  localparam int EAC_STALL_CYC = 2; // cpu halt per access
  localparam int EAC_WR_TIME_US = 4000; // longest write time, low supply
  localparam int EAC_WR_CYC = (EAC_WR_TIME_US * (EAC_CLK_HZ / 1_000_000)); // 40000
  // memory shape
  localparam int EAC_AW = 7;
  localparam int EAC_DW = 8;
  // cpu i/o access carrier
  typedef struct packed {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [5:0] addr; // i/o offset
    logic [7:0] wdata; // write data
  } eac_io_type;
  // memory port carrier
  typedef struct packed {
    logic we; // write enable
    logic re; // read enable
    logic [EAC_AW-1:0] addr;
    logic [EAC_DW-1:0] wdata;
  } eac_mem_type;
  // write sequencer states
  typedef enum logic [1:0] {
    EAC_IDLE = 2'b00,
    EAC_BUSY = 2'b01,
    EAC_DONE = 2'b10
  } eac_state_type;
endpackage

// *** design/eac_mem.sv ***
// eac_mem: byte-wide nonvolatile array model, registered read data
// assumes one access per cycle from the control block
`timescale 1ns/1ps
module eac_mem
  import eac_pkg::*;
#(
  parameter int AW = EAC_AW,
  parameter int DW = EAC_DW
) (
  // clock
  input wire logic mclk_i,
  // access port
  input wire eac_mem_type port_i,
  output logic [DW-1:0] rdata_o
);
  // array starts erased; the initialiser keeps the write process the only writer
  logic [DW-1:0] mem_r [0:(1<<AW)-1] = '{default: EAC_ERASED}; // cell array
  // only the 128 by 8 shape is served
  if (AW != EAC_AW || DW != EAC_DW) begin : g_bad_shape
    $error("eac_mem: unsupported shape");
  end
  // write port
  always_ff @(posedge mclk_i) begin
    if (port_i.we) begin
      mem_r[port_i.addr] <= port_i.wdata;
    end
  end
  // registered read
  always_ff @(posedge mclk_i) begin
    if (port_i.re) begin
      rdata_o <= mem_r[port_i.addr];
    end
  end
endmodule

// *** design/eac_top.sv ***
// eac_top: cpu i/o registers driving the on-chip eeprom array
// assumes a single-cycle i/o bus from the cpu on mclk_i, same clock domain
`timescale 1ns/1ps
import eac_pkg::*;
module eac_top
  import eac_pkg::*;
#(
  parameter int WR_CYC = EAC_WR_CYC // write duration in clocks
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // cpu i/o bus
  input wire eac_io_type io_i,
  output logic [7:0] io_rdata_o,
  // cpu halt request
  output logic cpu_halt_o,
  // status
  output logic wr_busy_o
);
  // refuse a write time the timer cannot count
  // the timer is sized from WR_CYC, so any positive value fits
  if (WR_CYC < 1) begin : g_bad_wr_cyc
    $error("eac_top: WR_CYC must be at least 1");
  end
  // the arm and halt counters are three and two bits wide
  if (EAC_ARM_CYC < 1 || EAC_ARM_CYC > 7) begin : g_bad_arm_cyc
    $error("eac_top: arm lifetime out of range");
  end
  if (EAC_STALL_CYC < 1 || EAC_STALL_CYC > 3) begin : g_bad_stall_cyc
    $error("eac_top: halt length out of range");
  end

  // decode helper for i/o writes
  // shared by the three register write decodes
  function automatic logic hit(input eac_io_type b, input logic [5:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  logic [EAC_AW-1:0] addr_r; // byte address
  logic [7:0] data_r; // data register
  logic arm_r; // write arm bit
  logic [2:0] arm_cnt_r; // arm lifetime counter
  logic wstb_r; // write strobe bit
  logic rstb_r; // read strobe bit
  logic rd_pend_r; // read data returns next cycle
  logic [1:0] halt_cnt_r; // remaining halt cycles
  logic [$clog2(WR_CYC+1)-1:0] wr_cnt_r; // write timer, sized from WR_CYC
  eac_state_type state_r; // write sequencer
  eac_mem_type mem_port; // array access
  logic [7:0] mem_rdata; // array read data
  logic ctrl_wr; // control write this cycle
  logic wr_start; // armed write strobe
  logic rd_start; // read strobe set

  assign ctrl_wr = hit(io_i, EAC_CTRL_OFS);
  // strobe needs arm still live
  assign wr_start = ctrl_wr && io_i.wdata[EAC_WR_BIT] && arm_r && (state_r == EAC_IDLE);
  assign rd_start = ctrl_wr && io_i.wdata[EAC_RD_BIT] && !wstb_r;

  // address register, no guard during a write
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_r <= EAC_AW'(EAC_RST_VAL);
    end else if (hit(io_i, EAC_ADDR_OFS)) begin
      addr_r <= io_i.wdata[EAC_AW-1:0];
    end
  end

  // data register, cpu write or read return
  // the fetched byte wins over a cpu write landing in the same cycle
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_r <= EAC_RST_VAL;
    end else if (rd_pend_r) begin
      data_r <= mem_rdata; // fetched byte
    end else if (hit(io_i, EAC_DATA_OFS)) begin
      data_r <= io_i.wdata;
    end
  end

  // arm bit with four-cycle lifetime
  // a fresh arm write restarts the lifetime, so it wins over expiry
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      arm_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else if (ctrl_wr && io_i.wdata[EAC_ARM_BIT]) begin
      arm_r <= 1'b1;
      arm_cnt_r <= 3'(EAC_ARM_CYC);
    end else if (arm_r) begin
      if (arm_cnt_r == 3'h1) begin
        arm_r <= 1'b0; // expired
      end
      arm_cnt_r <= arm_cnt_r - 3'h1;
    end
  end

  // write sequencer and write strobe
  // idle: waits for a strobe while the arm is live
  // busy: counts WR_CYC cycles of self-timed programming
  // done: commits the byte and drops the strobe for polling
  // a strobe while busy or done is ignored
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= EAC_IDLE;
      wstb_r <= 1'b0;
      wr_cnt_r <= '0;
    end else begin
      case (state_r)
        EAC_IDLE: begin
          if (wr_start) begin
            state_r <= EAC_BUSY;
            wstb_r <= 1'b1;
            wr_cnt_r <= ($bits(wr_cnt_r))'(WR_CYC - 1);
          end
        end
        EAC_BUSY: begin
          if (wr_cnt_r == '0) begin
            state_r <= EAC_DONE;
          end else begin
            wr_cnt_r <= wr_cnt_r - 1'b1;
          end
        end
        EAC_DONE: begin
          state_r <= EAC_IDLE;
          wstb_r <= 1'b0; // polled completion
        end
        default: begin
          state_r <= EAC_IDLE;
          wstb_r <= 1'b0;
        end
      endcase
    end
  end

  // read strobe, clears after the fetch
  // the strobe stays up only while the byte is on its way
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rstb_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_start;
      if (rd_start) begin
        rstb_r <= 1'b1;
      end else if (rd_pend_r) begin
        rstb_r <= 1'b0;
      end
    end
  end

  // halt the cpu two cycles per access
  // a new access restarts the count rather than adding to it
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      halt_cnt_r <= 2'h0;
    end else if (wr_start || rd_start) begin
      halt_cnt_r <= 2'(EAC_STALL_CYC);
    end else if (halt_cnt_r != 2'h0) begin
      halt_cnt_r <= halt_cnt_r - 2'h1;
    end
  end
  assign cpu_halt_o = (halt_cnt_r != 2'h0);
  assign wr_busy_o = wstb_r;

  // array port: write commits at the end using live registers
  // hazard: address and data are not latched at start, so cpu writes leak in
  always_comb begin
    mem_port.we = (state_r == EAC_DONE);
    mem_port.re = rd_start;
    mem_port.addr = addr_r;
    mem_port.wdata = data_r;
  end

  eac_mem #(
    .AW(EAC_AW),
    .DW(EAC_DW)
  ) u_mem (
    .mclk_i(mclk_i),
    .port_i(mem_port),
    .rdata_o(mem_rdata)
  );

  // read mux, reserved bits zero
  // every cycle returns the register at the presented offset
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_rdata_o <= 8'h00;
    end else begin
      case (io_i.addr)
        EAC_ADDR_OFS: io_rdata_o <= {1'b0, addr_r};
        EAC_DATA_OFS: io_rdata_o <= data_r;
        EAC_CTRL_OFS: io_rdata_o <= {5'h00, arm_r, wstb_r, rstb_r};
        default: io_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

// *** sim/eac_top_checker.sv ***
// eac_top_checker: port assertions for the eeprom access block
// assumes one clock domain, async active-high reset
`timescale 1ns/1ps
module eac_top_checker
  import eac_pkg::*;
#(
  parameter int WR_CYC = EAC_WR_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire eac_io_type io_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic cpu_halt_o,
  input wire logic wr_busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic ctl_wr; // control register write
  logic [2:0] arm_age_r; // arm life left
  int busy_len_r; // cycles of the running write
  logic arm_live; // model says the arm is still set
  assign arm_live = (arm_age_r != 3'h0);
  assign ctl_wr = io_i.wr && io_i.addr == EAC_CTRL_OFS;
  // arm lifetime model
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) arm_age_r <= 3'h0;
    else if (ctl_wr && io_i.wdata[EAC_ARM_BIT]) arm_age_r <= 3'h4;
    else if (arm_age_r != 3'h0) arm_age_r <= arm_age_r - 3'h1;
  end
  // write length counter
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) busy_len_r <= 0;
    else busy_len_r <= wr_busy_o ? busy_len_r + 1 : 0;
  end
  sequence s_halt2;
    cpu_halt_o [*2] ##1 !cpu_halt_o;
  endsequence
  a_halt_two: assert property ($rose(cpu_halt_o) |-> s_halt2)
    else $error("halt not two cycles");
  a_read_halt: assert property (ctl_wr && io_i.wdata[EAC_RD_BIT] && !wr_busy_o
    && !cpu_halt_o |=> cpu_halt_o) else $error("read did not halt");
  a_write_halt: assert property ($rose(wr_busy_o) |-> cpu_halt_o)
    else $error("write did not halt");
  a_write_len: assert property ($fell(wr_busy_o) |-> busy_len_r == WR_CYC + 1)
    else $error("write length wrong");
  a_no_arm: assert property (ctl_wr && io_i.wdata[EAC_WR_BIT] && arm_age_r == 0
    && !wr_busy_o |=> !wr_busy_o) else $error("unarmed write started");
  a_arm_start: assert property (ctl_wr && io_i.wdata[EAC_WR_BIT] && arm_age_r >= 1
    && !wr_busy_o |=> wr_busy_o) else $error("armed write missing");
  a_ctrl_resvd: assert property (io_i.addr == EAC_CTRL_OFS |=> io_rdata_o[7:3] == 5'h00)
    else $error("control high bits set");
  a_addr_msb: assert property (io_i.addr == EAC_ADDR_OFS |=> !io_rdata_o[7])
    else $error("address bit 7 set");
  a_arm_lapse: assert property (io_i.addr == EAC_CTRL_OFS
    |=> io_rdata_o[2] == $past(arm_live)) else $error("arm lifetime wrong");
endmodule
bind eac_top eac_top_checker #(.WR_CYC(WR_CYC)) u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .io_i(io_i), .io_rdata_o(io_rdata_o), .cpu_halt_o(cpu_halt_o), .wr_busy_o(wr_busy_o));

// *** sim/test_eeprom_access_control.sv ***
// test_eeprom_access_control: self-checking bench for eac_top
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module test_eeprom_access_control;
  import eac_pkg::*;
  localparam int WR = 20; // shortened write time
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  eac_io_type io_i = '0;
  logic [7:0] io_rdata_o;
  logic cpu_halt_o;
  logic wr_busy_o;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  // rows: offset, written value, value read back
  logic [21:0] rows [3] = '{{EAC_ADDR_OFS, 8'hff, 8'h7f}, {EAC_DATA_OFS, 8'ha5, 8'ha5},
    {EAC_CTRL_OFS, 8'hf8, 8'h00}};
  eac_top #(.WR_CYC(WR)) uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .io_i(io_i),
    .io_rdata_o(io_rdata_o), .cpu_halt_o(cpu_halt_o), .wr_busy_o(wr_busy_o));
  initial forever #50 mclk_i = ~mclk_i;
  // one bus cycle, driven just after the edge
  task automatic step(input logic w, input logic [5:0] a, input logic [7:0] d);
    io_i = {w, 1'b0, a, d};
    @(posedge mclk_i);
    #2;
  endtask
  // set address, strobe a read, fetch the data register
  task automatic mem_rd(input logic [6:0] a, input logic [7:0] e);
    step(1'b1, EAC_DATA_OFS, ~e);
    step(1'b1, EAC_ADDR_OFS, {1'b0, a});
    step(1'b1, EAC_CTRL_OFS, 8'h01);
    `CHK(cpu_halt_o, 1'b1)
    step(1'b0, EAC_DATA_OFS, 8'h00);
    step(1'b0, EAC_DATA_OFS, 8'h00);
    `CHK(io_rdata_o, e)
    `CHK(cpu_halt_o, 1'b0)
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hung write
  initial begin
    repeat (2000) @(posedge mclk_i);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    #2 sys_rst_i = 1'b0;
    `CHK({cpu_halt_o, wr_busy_o}, 2'b00)
    for (n = 0; n < 3; n++) begin
      step(1'b0, rows[n][21:16], 8'h00);
      `CHK(io_rdata_o, 8'h00)
    end
    for (n = 0; n < 3; n++) begin
      step(1'b1, rows[n][21:16], rows[n][15:8]);
      step(1'b0, rows[n][21:16], 8'h00);
      `CHK(io_rdata_o, rows[n][7:0])
    end
    $display("test registers done");
    // armed write to the top location, strobe on the third of four armed cycles
    step(1'b1, EAC_ADDR_OFS, 8'hff);
    step(1'b1, EAC_DATA_OFS, 8'h3c);
    step(1'b1, EAC_CTRL_OFS, 8'h04);
    step(1'b0, EAC_CTRL_OFS, 8'h00);
    `CHK(io_rdata_o, 8'h04)
    step(1'b0, EAC_CTRL_OFS, 8'h00);
    step(1'b1, EAC_CTRL_OFS, 8'h02);
    `CHK({cpu_halt_o, wr_busy_o}, 2'b11)
    step(1'b0, EAC_CTRL_OFS, 8'h00);
    `CHK(io_rdata_o[1], 1'b1)
    n = 0;
    while (wr_busy_o === 1'b1 && n < 100) begin
      step(1'b0, EAC_CTRL_OFS, 8'h00);
      n++;
    end
    step(1'b0, EAC_CTRL_OFS, 8'h00);
    `CHK(io_rdata_o, 8'h00)
    mem_rd(7'h7f, 8'h3c);
    step(1'b0, EAC_CTRL_OFS, 8'h00);
    `CHK(io_rdata_o, 8'h00)
    $display("test write done");
    // strobe with no arm, then after the arm has lapsed
    step(1'b1, EAC_ADDR_OFS, 8'h05);
    step(1'b1, EAC_DATA_OFS, 8'h11);
    step(1'b1, EAC_CTRL_OFS, 8'h02);
    `CHK(wr_busy_o, 1'b0)
    step(1'b1, EAC_CTRL_OFS, 8'h04);
    repeat (5) step(1'b0, EAC_CTRL_OFS, 8'h00);
    `CHK(io_rdata_o, 8'h00)
    step(1'b1, EAC_CTRL_OFS, 8'h02);
    `CHK(wr_busy_o, 1'b0)
    mem_rd(7'h05, EAC_ERASED);
    $display("test refusal done");
    // arm and strobe in one write is refused, reset cuts a running write
    step(1'b1, EAC_DATA_OFS, 8'h5a);
    step(1'b1, EAC_CTRL_OFS, 8'h06);
    `CHK(wr_busy_o, 1'b0)
    step(1'b1, EAC_CTRL_OFS, 8'h02);
    `CHK(wr_busy_o, 1'b1)
    sys_rst_i = 1'b1;
    repeat (2) step(1'b0, EAC_CTRL_OFS, 8'h00);
    sys_rst_i = 1'b0;
    `CHK({cpu_halt_o, wr_busy_o}, 2'b00)
    step(1'b0, EAC_CTRL_OFS, 8'h00);
    `CHK(io_rdata_o, 8'h00)
    mem_rd(7'h05, EAC_ERASED);
    $display("test reset done");
    conclude();
  end
endmodule
